/* hdl/clk_src_pkg.sv */
// constants for the clock source selection unit
// Behaviour
// - system clock output toggles at twice the bus clock rate.
// - selected source passes a bus divider of 1, 2, 4 or 8.
// - after reset the unit runs loop engaged, internally referenced.
// - engaged internal mode outputs loop clock, loop on internal reference.
// - engaged external mode outputs loop clock, loop on external reference.
// - bypassed internal keeps loop enabled, outputs internal reference.
// - bypassed internal low power disables loop, outputs internal reference.
// - bypassed external keeps loop enabled, outputs external reference.
// - bypassed external low power disables loop, outputs external reference.
// - stop disables loop and system clock; references run only if their stop retain bit is set.
// - loop reference up to 5 MHz, divided by a 3-bit select.
// - nine trim bits adjust the internal reference period.
// - source select bits 7:6 choose loop, internal, external; reserved acts as 00.
// - reference divided by two to the power of bits 5:3, reset 000.
// - bit 2 high references loop internally, low externally.
// - gated internal reference clock active only when bit 1 set.
// - in stop internal reference runs only if retained and enabled or used.
// - oscillator gain, range, request, enable, stop retain driven from control two.
// - bus divider bits 7:6 encode 1, 2, 4, 8, reset divide by 2.
// - status bits 3:2 report active mode, updated after synchronised switch.
// - oscillator ready sets after start-up edges, clears on request clear, or on enable clear while the external reference is unused.
`default_nettype none
package clk_src_pkg;
    localparam logic [9:0] IDX_CTL_ONE   = 10'h000;
    localparam logic [9:0] IDX_CTL_TWO   = 10'h001;
    localparam logic [9:0] IDX_TRIM      = 10'h002;
    localparam logic [9:0] IDX_STAT      = 10'h003;
    localparam logic [7:0] RST_CTL_ONE   = 8'h04;
    localparam logic [7:0] RST_CTL_TWO   = 8'h40;
    localparam logic [7:0] RST_TRIM      = 8'h80;
    localparam logic       RST_FINE_TRIM_BIT     = 1'h0;
    localparam int         SEL_HI        = 7;
    localparam int         SEL_LO        = 6;
    localparam int         REFERENCE_DIVIDER_SELECT_HI       = 5;
    localparam int         REFERENCE_DIVIDER_SELECT_LO       = 3;
    localparam int         IREF_BIT      = 2;
    localparam int         IREN_BIT      = 1;
    localparam int         IRST_BIT      = 0;
    localparam int         BUS_DIVIDER_SELECT_HI       = 7;
    localparam int         BUS_DIVIDER_SELECT_LO       = 6;
    localparam int         RANGE_BIT     = 5;
    localparam int         HGO_BIT       = 4;
    localparam int         LP_BIT        = 3;
    localparam int         OREQ_BIT      = 2;
    localparam int         EREN_BIT      = 1;
    localparam int         ERST_BIT      = 0;
    localparam int         ADDR_IDX_HI   = 11;
    localparam int         ADDR_IDX_LO   = 2;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ    = 2'h3;
    typedef enum logic [1:0] {
        MODE_LOOP = 2'b00,
        MODE_INT  = 2'b01,
        MODE_EXT  = 2'b10,
        MODE_RSVD = 2'b11
    } mode_t;
    typedef enum logic [1:0] {
        SW_IDLE = 2'b00,
        SW_OLD  = 2'b01,
        SW_NEW  = 2'b10
    } sw_state_t;
endpackage
`default_nettype wire

/* hdl/clk_src_sel.sv */
// clock source selection unit with AHB-Lite register slave
//
// Implementation choices: the address map and the AHB-Lite interface to the registers.
`default_nettype none
module clk_src_sel #(
    parameter int OSC_INIT_EDGES = 4096
) (
    // system
    input  wire logic         CLK_IN,
    input  wire logic         NRST_IN,
    // AHB-Lite slave
    input  wire logic         HSEL_IN,
    input  wire logic [31:0]  HADDR_IN,
    input  wire logic [1:0]   HTRANS_IN,
    input  wire logic         HWRITE_IN,
    input  wire logic [2:0]   HSIZE_IN,
    input  wire logic [31:0]  HWDATA_IN,
    input  wire logic         HREADY_IN,
    output logic      [31:0]  HRDATA_OUT,
    output logic              HREADYOUT_OUT,
    output logic              HRESP_OUT,
    // clock sources, sampled as levels
    input  wire logic         IRC_CLK_IN,
    input  wire logic         ERC_CLK_IN,
    input  wire logic         LOOP_CLK_IN,
    input  wire logic         STOP_IN,
    // generated clocks
    output logic              SYSTEM_CLOCK_OUT,
    output logic              BUS_CLOCK_OUT,
    output logic              GATED_INTERNAL_REFERENCE_CLOCK_OUT,
    output logic              GATED_EXTERNAL_REFERENCE_CLOCK_OUT,
    // loop and internal reference control
    output logic              LOOP_ENABLE_OUT,
    output logic              LOOP_REF_INTERNAL_OUT,
    output logic              LOOP_REF_TICK_OUT,
    output logic              IRC_RUN_OUT,
    output logic      [8:0]   IRC_TRIM_OUT,
    // external oscillator control
    output logic              OSCILLATOR_HIGH_GAIN_OUT,
    output logic              OSC_HIGH_RANGE_OUT,
    output logic              OSCILLATOR_REQUEST_OUT,
    output logic              EXTERNAL_REFERENCE_ENABLE_OUT,
    output logic              EXTERNAL_REFERENCE_STOP_RETAIN_OUT
);
    import clk_src_pkg::*;

    localparam logic [12:0] OSC_LAST = 13'(OSC_INIT_EDGES - 1);

    function automatic logic [6:0] pow2_mask(input logic [2:0] e);
        pow2_mask = 7'((8'h01 << e) - 8'h01);
    endfunction

    logic [7:0]  ctl_one_ff;
    logic [7:0]  ctl_two_ff;
    logic [7:0]  trim_ff;
    logic        fine_trim_bit_ff;
    logic        wr_pend_ff;
    logic        rd_pend_ff;
    logic [9:0]  idx_ff;
    logic        hready_ff;
    logic [31:0] hrdata_ff;
    logic [31:0] nxt_rdata;
    logic        addr_ok;

    mode_t       stat_ff;
    mode_t       target_ff;
    mode_t       sel_eff;
    sw_state_t   sw_ff;
    logic        irc_q_ff;
    logic        erc_q_ff;
    logic        loop_q_ff;
    logic        stop_q_ff;
    logic        was_int_ff;
    logic        was_ext_ff;
    logic [2:0]  bcnt_ff;
    logic [6:0]  rcnt_ff;
    logic [12:0] ocnt_ff;
    logic        osc_ready_ff;
    logic        sys_ff;
    logic        bus_ff;
    logic        ref_tick_ff;
    logic        loop_en_ff;
    logic        irc_run_ff;
    logic        girc_ff;
    logic        gerc_ff;

    logic        irc_rise;
    logic        erc_rise;
    logic        loop_rise;
    logic        ref_rise;
    logic        old_rise;
    logic        new_rise;
    logic        src_rise;
    logic        pass_rise;
    logic        int_used;
    logic        ext_used;
    logic        osc_want;
    logic        irc_gate;
    logic        erc_gate;
    logic [6:0]  bmask;

    // ---------------- register slave ----------------
    assign addr_ok = (HADDR_IN[31:ADDR_IDX_HI+1] == '0) && (HADDR_IN[ADDR_IDX_HI:ADDR_IDX_LO] <= IDX_STAT);

    always_ff @(posedge CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            wr_pend_ff <= 1'b0;
            rd_pend_ff <= 1'b0;
            idx_ff     <= '0;
        end else begin
            wr_pend_ff <= 1'b0;
            rd_pend_ff <= 1'b0;
            if (HSEL_IN && HREADY_IN && (HTRANS_IN == HTRANS_NONSEQ || HTRANS_IN == HTRANS_SEQ)) begin
                wr_pend_ff <= HWRITE_IN && addr_ok;
                rd_pend_ff <= !HWRITE_IN;
                idx_ff     <= addr_ok ? HADDR_IN[ADDR_IDX_HI:ADDR_IDX_LO] : IDX_STAT + 10'h001;
            end
        end
    end

    // reads take one wait state so the word is sampled after any preceding write
    always_ff @(posedge CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            hready_ff <= 1'b1;
        end else begin
            hready_ff <= !(HSEL_IN && HREADY_IN && !HWRITE_IN
                           && (HTRANS_IN == HTRANS_NONSEQ || HTRANS_IN == HTRANS_SEQ));
        end
    end

    always_comb begin
        nxt_rdata = 32'h0000_0000;
        case (idx_ff)
            IDX_CTL_ONE: nxt_rdata[7:0] = ctl_one_ff;
            IDX_CTL_TWO: nxt_rdata[7:0] = ctl_two_ff;
            IDX_TRIM:    nxt_rdata[7:0] = trim_ff;
            IDX_STAT:    nxt_rdata[3:0] = {stat_ff, osc_ready_ff, fine_trim_bit_ff};
            default:     nxt_rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            hrdata_ff <= 32'h0000_0000;
        end else if (rd_pend_ff) begin
            hrdata_ff <= nxt_rdata;
        end
    end

    always_ff @(posedge CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            ctl_one_ff <= RST_CTL_ONE;
            ctl_two_ff <= RST_CTL_TWO;
            trim_ff    <= RST_TRIM;
            fine_trim_bit_ff   <= RST_FINE_TRIM_BIT;
        end else if (wr_pend_ff) begin
            case (idx_ff)
                IDX_CTL_ONE: ctl_one_ff <= HWDATA_IN[7:0];
                IDX_CTL_TWO: ctl_two_ff <= HWDATA_IN[7:0];
                IDX_TRIM:    trim_ff    <= HWDATA_IN[7:0];
                IDX_STAT:    fine_trim_bit_ff   <= HWDATA_IN[0];
                default:     ;
            endcase
        end
    end

    // ---------------- source edges and mode decode ----------------
    always_ff @(posedge CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            irc_q_ff  <= 1'b0;
            erc_q_ff  <= 1'b0;
            loop_q_ff <= 1'b0;
            stop_q_ff <= 1'b0;
        end else begin
            irc_q_ff  <= IRC_CLK_IN;
            erc_q_ff  <= ERC_CLK_IN;
            loop_q_ff <= LOOP_CLK_IN;
            stop_q_ff <= STOP_IN;
        end
    end

    assign irc_rise  = IRC_CLK_IN && !irc_q_ff;
    assign erc_rise  = ERC_CLK_IN && !erc_q_ff;
    assign loop_rise = LOOP_CLK_IN && !loop_q_ff;
    assign sel_eff   = (ctl_one_ff[SEL_HI:SEL_LO] == MODE_RSVD) ? MODE_LOOP
                     : mode_t'(ctl_one_ff[SEL_HI:SEL_LO]);
    assign int_used  = (stat_ff == MODE_INT) || (stat_ff == MODE_LOOP && ctl_one_ff[IREF_BIT]);
    assign ext_used  = (stat_ff == MODE_EXT) || (stat_ff == MODE_LOOP && !ctl_one_ff[IREF_BIT]);
    assign ref_rise  = ctl_one_ff[IREF_BIT] ? irc_rise : erc_rise;

    always_comb begin
        old_rise = loop_rise;
        new_rise = loop_rise;
        case (stat_ff)
            MODE_INT: old_rise = irc_rise;
            MODE_EXT: old_rise = erc_rise;
            default:  old_rise = loop_rise;
        endcase
        case (target_ff)
            MODE_INT: new_rise = irc_rise;
            MODE_EXT: new_rise = erc_rise;
            default:  new_rise = loop_rise;
        endcase
    end

    assign src_rise  = old_rise;
    assign pass_rise = src_rise && (sw_ff == SW_IDLE) && !STOP_IN;

    // ---------------- glitch-free source switch ----------------
    always_ff @(posedge CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            sw_ff     <= SW_IDLE;
            stat_ff   <= MODE_LOOP;
            target_ff <= MODE_LOOP;
        end else begin
            case (sw_ff)
                SW_IDLE: begin
                    if (sel_eff != stat_ff) begin
                        target_ff <= sel_eff;
                        sw_ff     <= SW_OLD;
                    end
                end
                SW_OLD: begin
                    if (old_rise) begin
                        sw_ff <= SW_NEW;
                    end
                end
                SW_NEW: begin
                    if (new_rise) begin
                        stat_ff <= target_ff;
                        sw_ff   <= SW_IDLE;
                    end
                end
                default: sw_ff <= SW_IDLE;
            endcase
        end
    end

    // ---------------- bus divider and output clocks ----------------
    assign bmask = pow2_mask({1'b0, ctl_two_ff[BUS_DIVIDER_SELECT_HI:BUS_DIVIDER_SELECT_LO]});

    always_ff @(posedge CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            bcnt_ff <= '0;
            sys_ff  <= 1'b0;
            bus_ff  <= 1'b0;
        end else if (pass_rise) begin
            if (bcnt_ff == bmask[2:0]) begin
                bcnt_ff <= '0;
                sys_ff  <= !sys_ff;
                if (!sys_ff) begin
                    bus_ff <= !bus_ff;
                end
            end else begin
                bcnt_ff <= 3'(bcnt_ff + 3'h1);
            end
        end
    end

    // ---------------- loop reference divider ----------------
    always_ff @(posedge CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            rcnt_ff     <= '0;
            ref_tick_ff <= 1'b0;
        end else begin
            ref_tick_ff <= 1'b0;
            if (ref_rise && loop_en_ff) begin
                if (rcnt_ff == pow2_mask(ctl_one_ff[REFERENCE_DIVIDER_SELECT_HI:REFERENCE_DIVIDER_SELECT_LO])) begin
                    rcnt_ff     <= '0;
                    ref_tick_ff <= 1'b1;
                end else begin
                    rcnt_ff <= 7'(rcnt_ff + 7'h01);
                end
            end
        end
    end

    // ---------------- stop retention and reference gating ----------------
    always_ff @(posedge CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            was_int_ff <= 1'b0;
            was_ext_ff <= 1'b0;
        end else if (STOP_IN && !stop_q_ff) begin
            was_int_ff <= int_used;
            was_ext_ff <= ext_used;
        end
    end

    assign irc_gate = STOP_IN ? (ctl_one_ff[IRST_BIT] && (ctl_one_ff[IREN_BIT] || was_int_ff))
                              : 1'b1;
    assign erc_gate = STOP_IN ? (ctl_two_ff[ERST_BIT] && (ctl_two_ff[EREN_BIT] || was_ext_ff))
                              : 1'b1;
    assign osc_want = ctl_two_ff[OREQ_BIT] && (ctl_two_ff[EREN_BIT] || ext_used);

    always_ff @(posedge CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            loop_en_ff <= 1'b1;
            irc_run_ff <= 1'b1;
            girc_ff    <= 1'b0;
            gerc_ff    <= 1'b0;
        end else begin
            loop_en_ff <= !STOP_IN && !(stat_ff != MODE_LOOP && ctl_two_ff[LP_BIT]);
            irc_run_ff <= STOP_IN ? irc_gate : (ctl_one_ff[IREN_BIT] || int_used);
            girc_ff    <= IRC_CLK_IN && ctl_one_ff[IREN_BIT] && irc_gate;
            gerc_ff    <= ERC_CLK_IN && ctl_two_ff[EREN_BIT] && erc_gate;
        end
    end

    // ---------------- oscillator start-up ----------------
    always_ff @(posedge CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            ocnt_ff      <= '0;
            osc_ready_ff <= 1'b0;
        end else if (!ctl_two_ff[OREQ_BIT] || !ctl_two_ff[EREN_BIT] && !ext_used) begin
            ocnt_ff      <= '0;
            osc_ready_ff <= 1'b0;
        end else if (osc_want && erc_rise && !osc_ready_ff) begin
            if (ocnt_ff == OSC_LAST) begin
                osc_ready_ff <= 1'b1;
            end else begin
                ocnt_ff <= 13'(ocnt_ff + 13'h0001);
            end
        end
    end

    // ---------------- outputs ----------------
    assign HRDATA_OUT                         = hrdata_ff;
    assign HREADYOUT_OUT                      = hready_ff;
    assign HRESP_OUT                          = 1'b0;
    assign SYSTEM_CLOCK_OUT                   = sys_ff;
    assign BUS_CLOCK_OUT                      = bus_ff;
    assign GATED_INTERNAL_REFERENCE_CLOCK_OUT = girc_ff;
    assign GATED_EXTERNAL_REFERENCE_CLOCK_OUT = gerc_ff;
    assign LOOP_ENABLE_OUT                    = loop_en_ff;
    assign LOOP_REF_INTERNAL_OUT              = ctl_one_ff[IREF_BIT];
    assign LOOP_REF_TICK_OUT                  = ref_tick_ff;
    assign IRC_RUN_OUT                        = irc_run_ff;
    assign IRC_TRIM_OUT                       = {trim_ff, fine_trim_bit_ff};
    assign OSCILLATOR_HIGH_GAIN_OUT           = ctl_two_ff[HGO_BIT];
    assign OSC_HIGH_RANGE_OUT                 = ctl_two_ff[RANGE_BIT];
    assign OSCILLATOR_REQUEST_OUT             = ctl_two_ff[OREQ_BIT];
    assign EXTERNAL_REFERENCE_ENABLE_OUT      = ctl_two_ff[EREN_BIT];
    assign EXTERNAL_REFERENCE_STOP_RETAIN_OUT = ctl_two_ff[ERST_BIT];

    // ---------------- assertions ----------------
    sequence s_switch_armed;
        sw_ff == SW_OLD && old_rise;
    endsequence

    sequence s_switch_done;
        sw_ff == SW_NEW && new_rise;
    endsequence

    property p_switch_needs_arm;
        @(posedge CLK_IN) disable iff (!NRST_IN) s_switch_armed |=> sw_ff == SW_NEW;
    endproperty
    a_switch_needs_arm: assert property (p_switch_needs_arm) else $error("switch skipped old edge");

    property p_status_after_switch;
        @(posedge CLK_IN) disable iff (!NRST_IN) s_switch_done |=> stat_ff == $past(target_ff) && sw_ff == SW_IDLE;
    endproperty
    a_status_after_switch: assert property (p_status_after_switch) else $error("status not updated");

    property p_status_only_on_switch;
        @(posedge CLK_IN) disable iff (!NRST_IN) !$stable(stat_ff) |-> $past(sw_ff) == SW_NEW;
    endproperty
    a_status_only_on_switch: assert property (p_status_only_on_switch) else $error("status changed early");

    property p_no_clock_in_stop;
        @(posedge CLK_IN) disable iff (!NRST_IN) STOP_IN |=> $stable(sys_ff) && !loop_en_ff;
    endproperty
    a_no_clock_in_stop: assert property (p_no_clock_in_stop) else $error("clock ran in stop");

    property p_bus_half_sys;
        @(posedge CLK_IN) disable iff (!NRST_IN) $rose(sys_ff) |-> bus_ff != $past(bus_ff);
    endproperty
    a_bus_half_sys: assert property (p_bus_half_sys) else $error("bus clock not half rate");

    property p_divider_count;
        @(posedge CLK_IN) disable iff (!NRST_IN) pass_rise && bcnt_ff != bmask[2:0] |=> $stable(sys_ff);
    endproperty
    a_divider_count: assert property (p_divider_count) else $error("divider toggled early");

    property p_irc_gate_off;
        @(posedge CLK_IN) disable iff (!NRST_IN) !ctl_one_ff[IREN_BIT] |=> !girc_ff;
    endproperty
    a_irc_gate_off: assert property (p_irc_gate_off) else $error("internal clock leaked");

    property p_irc_stop_drop;
        @(posedge CLK_IN) disable iff (!NRST_IN) STOP_IN && !ctl_one_ff[IRST_BIT] |=> !irc_run_ff;
    endproperty
    a_irc_stop_drop: assert property (p_irc_stop_drop) else $error("internal reference kept in stop");

    property p_ready_clears;
        @(posedge CLK_IN) disable iff (!NRST_IN) !ctl_two_ff[OREQ_BIT] |=> !osc_ready_ff;
    endproperty
    a_ready_clears: assert property (p_ready_clears) else $error("oscillator ready stuck");

    property p_ref_tick;
        @(posedge CLK_IN) disable iff (!NRST_IN) ref_tick_ff |-> $past(rcnt_ff) == $past(pow2_mask(ctl_one_ff[REFERENCE_DIVIDER_SELECT_HI:REFERENCE_DIVIDER_SELECT_LO]));
    endproperty
    a_ref_tick: assert property (p_ref_tick) else $error("reference divider off");
endmodule
`default_nettype wire

/* bench/clk_src_partner.sv */
// model of the reference and loop oscillators; external and loop run free, internal is held low while irc_run_in is low
`default_nettype none
module clk_src_partner (
    // control
    input  wire logic clk_in,
    input  wire logic irc_run_in,
    // oscillators
    output logic      irc_out,
    output logic      erc_out,
    output logic      loop_out
);
    timeunit 1ns;
    timeprecision 100ps;
    int cnt = 0;
    initial begin
        irc_out = 1'b0;
        erc_out = 1'b0;
        loop_out = 1'b0;
    end
    // every source stays well below half the sampling clock
    always @(posedge clk_in) begin
        cnt <= cnt + 1;
        if (cnt % 5 == 4) irc_out <= irc_run_in ? !irc_out : 1'b0;
        if (cnt % 3 == 2) erc_out <= !erc_out;
        if (cnt % 2 == 1) loop_out <= !loop_out;
    end
endmodule
`default_nettype wire

/* bench/clk_src_sel_test.sv */
// self-checking bench for the clock source selection unit
`default_nettype none
module clk_src_sel_test;
    timeunit 1ns;
    timeprecision 100ps;
    import clk_src_pkg::*;
    localparam logic [31:0] A1 = {20'h0, IDX_CTL_ONE, 2'b00};
    localparam logic [31:0] A2 = {20'h0, IDX_CTL_TWO, 2'b00};
    localparam logic [31:0] AT = {20'h0, IDX_TRIM, 2'b00};
    localparam logic [31:0] AS = {20'h0, IDX_STAT, 2'b00};
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic        stop = 1'b0;
    logic [31:0] hrdata;
    logic        hready, hresp, irc, erc, lpc, sys, bus, girc, gerc, tick, lpen, ref_int, irc_run;
    logic [8:0]  trim;
    wire logic [4:0] osc;
    int          error_cnt = 0;
    int          tests_run = 0;
    int          n_sys, n_bus, n_gi, n_irc, n_ge, n_tk;

    initial begin
        forever #12.5 clk = ~clk;
    end

    clk_src_sel #(.OSC_INIT_EDGES(4)) i_dut (
        .CLK_IN(clk), .NRST_IN(nrst), .HSEL_IN(hsel), .HADDR_IN(haddr), .HTRANS_IN(htrans),
        .HWRITE_IN(hwrite), .HSIZE_IN(hsize), .HWDATA_IN(hwdata), .HREADY_IN(hready),
        .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready), .HRESP_OUT(hresp),
        .IRC_CLK_IN(irc), .ERC_CLK_IN(erc), .LOOP_CLK_IN(lpc), .STOP_IN(stop),
        .SYSTEM_CLOCK_OUT(sys), .BUS_CLOCK_OUT(bus), .GATED_INTERNAL_REFERENCE_CLOCK_OUT(girc),
        .GATED_EXTERNAL_REFERENCE_CLOCK_OUT(gerc), .LOOP_ENABLE_OUT(lpen), .LOOP_REF_INTERNAL_OUT(ref_int),
        .LOOP_REF_TICK_OUT(tick), .IRC_RUN_OUT(irc_run), .IRC_TRIM_OUT(trim),
        .OSCILLATOR_HIGH_GAIN_OUT(osc[3]), .OSC_HIGH_RANGE_OUT(osc[4]), .OSCILLATOR_REQUEST_OUT(osc[2]),
        .EXTERNAL_REFERENCE_ENABLE_OUT(osc[1]), .EXTERNAL_REFERENCE_STOP_RETAIN_OUT(osc[0]));

    clk_src_partner i_src (.clk_in(clk), .irc_run_in(irc_run), .irc_out(irc), .erc_out(erc), .loop_out(lpc));

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic final_report;
        $display("Checks %0d errors %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // one single transfer; entered just after a rising edge
    task automatic xfer(input logic w, input logic [31:0] a, input logic [7:0] d, output logic [31:0] q);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        q = hrdata;
    endtask

    task automatic wr(input logic [31:0] a, input logic [7:0] d);
        logic [31:0] q;
        xfer(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [31:0] a, output logic [31:0] q);
        xfer(1'b0, a, 8'h00, q);
    endtask

    task automatic wait_mode(input logic [1:0] m, output logic [31:0] q);
        q = 32'hFF;
        for (int k = 0; k < 40 && q[3:2] !== m; k++) rd(AS, q);
    endtask

    // two edges settle the outputs after the last register write before counting
    task automatic measure(input int n);
        logic ps, pb, pg, pi, pe;
        repeat (2) @(posedge clk);
        {n_sys, n_bus, n_gi, n_irc, n_ge, n_tk} = '0;
        {ps, pb, pg, pi, pe} = {sys, bus, girc, irc, gerc};
        repeat (n) begin
            @(posedge clk);
            if (sys !== ps) n_sys++;
            if (bus !== pb) n_bus++;
            if (girc !== pg) n_gi++;
            if (gerc !== pe) n_ge++;
            if (tick === 1'b1) n_tk++;
            if (irc === 1'b1 && pi === 1'b0) n_irc++;
            {ps, pb, pg, pi, pe} = {sys, bus, girc, irc, gerc};
        end
    endtask

    function automatic logic near(input int a, input int b, input int t);
        return (a - b <= t) && (b - a <= t);
    endfunction

    initial begin
        repeat (50000) @(posedge clk);
        error_cnt++;
        $display("Error watchdog expected finish seen hang");
        final_report();
    end

    initial begin
        logic [31:0] q;
        logic [1:0]  m;
        logic [9:0]  st;
        logic [4:0]  ir;
        st = 10'b01_10_11_00_00;
        ir = 5'b10101;
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        check("loop_en_rst", lpen, 1'b1);
        rd(A1, q);
        check("ctl1_rst", q, 32'h04);
        rd(A2, q);
        check("ctl2_rst", q, 32'h40);
        rd(AT, q);
        check("trim_rst", q, {24'h0, RST_TRIM});
        rd(AS, q);
        check("stat_rst", q, 32'h00);
        // unmapped word: write dropped, read zero
        wr(32'h10, 8'hFF);
        rd(32'h10, q);
        check("unmapped", q, 32'h0);
        wr(AT, 8'h5A);
        wr(AS, 8'hFF);
        rd(AS, q);
        check("fine_trim", q, 32'h01);
        check("trim_out", trim, 9'h0B5);
        wr(A2, 8'h25);
        rd(A2, q);
        check("osc_ctl", osc, 5'b10101);
        for (int lp = 0; lp < 2; lp++) begin
            wr(A2, 8'h37 | 8'(lp << 3));
            for (int i = 0; i < 5; i++) begin
                m = (st[2*i+:2] == 2'b11) ? 2'b00 : st[2*i+:2];
                wr(A1, {st[2*i+:2], 3'b000, ir[i], 2'b10});
                wait_mode(m, q);
                check("mode", q[3:2], m);
                check("loop_en", lpen, !(lp == 1 && m != 2'b00));
                check("loop_ref", ref_int, ir[i]);
            end
        end
        rd(AS, q);
        check("osc_ready", q[1], 1'b1);
        wr(A2, 8'h3B);
        rd(AS, q);
        check("osc_ready_clr", q[1], 1'b0);
        wr(A1, 8'h46);
        wait_mode(2'b01, q);
        for (int b = 0; b < 4; b++) begin
            wr(A2, 8'(b << 6));
            measure(400);
            check("bus_divider_select", near(n_sys, n_irc >> b, 1), 1'b1);
            check("bus_half", near(n_sys, 2 * n_bus, 2), 1'b1);
            check("ref_tick", near(n_tk, n_irc, 1), 1'b1);
            check("gerc_off", n_ge, 0);
        end
        wr(A1, 8'h44);
        measure(100);
        check("girc_off", n_gi, 0);
        wr(A2, 8'h02);
        wr(A1, 8'h46);
        measure(100);
        check("girc_on", near(n_gi, 2 * n_irc, 2) && n_gi > 0, 1'b1);
        check("gerc_on", n_ge > 0, 1'b1);
        wr(A1, 8'h47);
        stop <= 1'b1;
        measure(100);
        check("stop_loop", lpen, 1'b0);
        check("stop_sys", n_sys, 0);
        check("stop_keep", irc_run, 1'b1);
        check("stop_tick", n_tk, 0);
        check("stop_gerc", n_ge, 0);
        wr(A1, 8'h46);
        measure(100);
        check("stop_drop", irc_run, 1'b0);
        check("stop_girc", n_gi, 0);
        check("hresp", hresp, 1'b0);
        final_report();
    end
endmodule
`default_nettype wire
